// file: rtl/mac_control_options.sv
// mac control register, deference timing, duplex gating, receive checks
// assumes an apb master on pclk and a mac receive path on the same clock;
// carrier sense and line speed come from pins and are synchronised here
`timescale 1ns/1ps
// What this block does
// - codes A..F add 288 to 448 bits
// - codes 0..9 add 0 to 256 bits
// - enable bit lengthens post-transmit deferral
// - enable clear ignores defer time select
// - disabled: standard IFS, scaled to line rate
// - full duplex: no deferring to receive
// - full duplex masks carrier, stops lost-carrier
// - small allowance: oversize at 1519 bytes
// - large allowance: oversize at 4495 bytes
// - size counts addresses, type and FCS
// - collision-only bit selects extension style
// - pause enable acts on PAUSE frames
// - vendor tag clear: plain 802.3 frames
// - vendor tag: four bytes, first two masked
// - allowance clear: over max size flagged
// - allowance set: 802.1Q gets four more
// - oversize reported in upload status word
// - control bits 5 through 10 placed
// - control register clears on reset
module mac_control_options (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// line pins
	input  wire logic        speed_100_pin,
	input  wire logic        carrier_sense_pin,
	// transmit side
	input  wire logic        tx_end,
	input  wire logic        tx_collided,
	input  wire logic        tx_was_ours,
	input  wire logic        tx_carrier_lost,
	output logic             tx_hold_off,
	// receive side
	input  wire logic        rx_start,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_end,
	output logic      [15:0] upload_status_word,
	output logic             upload_status_valid,
	output logic             pause_seen,
	output logic      [15:0] pause_quanta,
	// configuration seen by the mac
	output logic             full_duplex_enable_a,
	output logic             transmit_reset_cmd,
	output logic             receive_reset_cmd
);
	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] max_pkt;
		logic [15:0] tag_mask;
		logic [15:0] lost_carrier_stat;
		logic [31:0] rdata;
		logic        rerr;
		logic [1:0]  spd_sync;
		logic [1:0]  crs_sync;
		logic [3:0]  bit_div;
		logic [9:0]  defer_cnt;
		logic [12:0] byte_cnt;
		logic [7:0]  prev_byte;
		logic [15:0] vendor_tag_field;
		logic        qtagged;
		logic        ctrl_type;
		logic        pause_opc;
		logic [15:0] quanta;
		logic [15:0] status;
		logic        status_vld;
		logic        pause_vld;
		logic [15:0] pause_q;
		logic        dup_changed;
	} state_t;

	state_t st_reg;
	state_t st_next;

	logic        setup;
	logic        wr_ok;
	logic [15:0] wdata16;
	logic        defer_en;
	logic        full_dup;
	logic        extend;
	logic [9:0]  defer_load;
	logic        bit_tick;
	logic [3:0]  bit_cycles;
	logic [12:0] base;
	logic [12:0] size_now;
	logic [12:0] ovs_floor;
	logic [12:0] max_allow;
	logic        too_long;
	logic        tag_reject;
	logic        is_pause;

	assign setup    = psel & ~penable;
	assign wr_ok    = psel & penable & pwrite & ~st_reg.rerr;
	assign defer_en = st_reg.ctrl[mac_ctl_pkg::B_DEFER_EN];
	assign full_dup = st_reg.ctrl[mac_ctl_pkg::B_FULL_DUP];

	always_comb begin
		st_next = st_reg;
		wdata16 = 16'h0000;

		// two-stage synchronisers for pin levels
		st_next.spd_sync = {st_reg.spd_sync[0], speed_100_pin};
		st_next.crs_sync = {st_reg.crs_sync[0], carrier_sense_pin};

		// read data and error are latched in setup, shown in access
		if (setup) begin
			st_next.rerr  = 1'b0;
			st_next.rdata = 32'h0000_0000;
			case (paddr)
				mac_ctl_pkg::OFF_MAC_CTRL:
					st_next.rdata = {16'h0000, st_reg.ctrl};
				mac_ctl_pkg::OFF_MAX_PKT:
					st_next.rdata = {16'h0000, st_reg.max_pkt};
				mac_ctl_pkg::OFF_TAG_MASK:
					st_next.rdata = {16'h0000, st_reg.tag_mask};
				mac_ctl_pkg::OFF_LOST_CARR:
					st_next.rdata = {16'h0000, st_reg.lost_carrier_stat};
				default:
					st_next.rerr = 1'b1;
			endcase
		end

		// byte lanes 0 and 1 carry the 16-bit registers
		st_next.dup_changed = 1'b0;
		if (wr_ok) begin
			wdata16 = st_reg.ctrl;
			case (paddr)
				mac_ctl_pkg::OFF_MAX_PKT:  wdata16 = st_reg.max_pkt;
				mac_ctl_pkg::OFF_TAG_MASK: wdata16 = st_reg.tag_mask;
				mac_ctl_pkg::OFF_LOST_CARR:
					wdata16 = st_reg.lost_carrier_stat;
				default:                   wdata16 = st_reg.ctrl;
			endcase
			if (pstrb[0])
				wdata16[7:0] = pwdata[7:0];
			if (pstrb[1])
				wdata16[15:8] = pwdata[15:8];
			case (paddr)
				mac_ctl_pkg::OFF_MAC_CTRL: begin
					st_next.ctrl = wdata16 & mac_ctl_pkg::MAC_CTRL_MASK;
					st_next.dup_changed =
						wdata16[mac_ctl_pkg::B_FULL_DUP] != full_dup;
				end
				mac_ctl_pkg::OFF_MAX_PKT:   st_next.max_pkt  = wdata16;
				mac_ctl_pkg::OFF_TAG_MASK:  st_next.tag_mask = wdata16;
				mac_ctl_pkg::OFF_LOST_CARR:
					st_next.lost_carrier_stat = wdata16;
				default: st_next.ctrl = st_reg.ctrl;
			endcase
		end

		if (tx_carrier_lost && !full_dup)
			st_next.lost_carrier_stat = st_reg.lost_carrier_stat + 16'h0001;

		// bit time tracks the active line rate
		bit_cycles = st_reg.spd_sync[1] ? mac_ctl_pkg::BIT_CYC_100M
		                                : mac_ctl_pkg::BIT_CYC_10M;
		bit_tick = st_reg.bit_div >= bit_cycles - 4'h1;
		st_next.bit_div = bit_tick ? 4'h0 : st_reg.bit_div + 4'h1;

		// extension after all, or only own collisions
		extend = st_reg.ctrl[mac_ctl_pkg::B_COLL_ONLY]
			? (tx_collided && tx_was_ours) : 1'b1;
		defer_load = mac_ctl_pkg::IFS_BITS;
		if (defer_en && extend)
			defer_load = mac_ctl_pkg::IFS_BITS + {1'b0,
				mac_ctl_pkg::EXT_BITS[st_reg.ctrl[4:1]]};
		// IFS plus any extension, counted in scaled bit times
		if (tx_end)
			st_next.defer_cnt = defer_load;
		else if (bit_tick && st_reg.defer_cnt != 10'd0)
			st_next.defer_cnt = st_reg.defer_cnt - 10'd1;

		// receive path
		base = st_reg.ctrl[mac_ctl_pkg::B_VTAG_EN]
			? mac_ctl_pkg::VTAG_LEN : 13'd0;
		size_now = st_reg.byte_cnt;
		if (rx_start) begin
			st_next.byte_cnt  = 13'd0;
			st_next.qtagged   = 1'b0;
			st_next.ctrl_type = 1'b0;
			st_next.pause_opc = 1'b0;
			st_next.vendor_tag_field = 16'h0000;
		end else if (rx_byte_valid) begin
			// every byte through the FCS counts
			if (st_reg.byte_cnt != 13'h1FFF)
				st_next.byte_cnt = st_reg.byte_cnt + 13'd1;
			st_next.prev_byte = rx_byte;
			if (base != 13'd0 && st_reg.byte_cnt < 13'd2)
				st_next.vendor_tag_field =
					{st_reg.vendor_tag_field[7:0], rx_byte};
			if (st_reg.byte_cnt == base + mac_ctl_pkg::TYPE_POS + 13'd1)
			begin
				st_next.qtagged =
					{st_reg.prev_byte, rx_byte} == mac_ctl_pkg::TYPE_QTAG;
				st_next.ctrl_type =
					{st_reg.prev_byte, rx_byte} == mac_ctl_pkg::TYPE_CTRL;
			end
			if (st_reg.byte_cnt == base + mac_ctl_pkg::TYPE_POS + 13'd3)
				st_next.pause_opc =
					{st_reg.prev_byte, rx_byte} == mac_ctl_pkg::OPC_PAUSE;
			if (st_reg.byte_cnt == base + mac_ctl_pkg::TYPE_POS + 13'd5)
				st_next.quanta = {st_reg.prev_byte, rx_byte};
		end

		ovs_floor = st_reg.ctrl[mac_ctl_pkg::B_LARGE_PKT]
			? mac_ctl_pkg::OVS_LARGE : mac_ctl_pkg::OVS_NORMAL;
		max_allow = st_reg.max_pkt[12:0];
		if (st_reg.ctrl[mac_ctl_pkg::B_TAG_OVS] && st_reg.qtagged)
			max_allow = st_reg.max_pkt[12:0] + mac_ctl_pkg::QTAG_EXTRA;
		too_long = size_now >= ovs_floor || size_now > max_allow;
		tag_reject = st_reg.ctrl[mac_ctl_pkg::B_VTAG_EN] &&
			(st_reg.vendor_tag_field & st_reg.tag_mask) == 16'h0000;
		// pause frames acted on only when enabled
		is_pause = st_reg.ctrl[mac_ctl_pkg::B_PAUSE_EN] &&
			st_reg.ctrl_type && st_reg.pause_opc;

		st_next.status_vld = 1'b0;
		st_next.pause_vld  = 1'b0;
		if (rx_end) begin
			st_next.status = {is_pause, tag_reject, too_long, size_now};
			st_next.status_vld = 1'b1;
			if (is_pause && !tag_reject) begin
				st_next.pause_vld = 1'b1;
				st_next.pause_q   = st_reg.quanta;
			end
		end
	end

	// whole control register zero at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.ctrl     <= mac_ctl_pkg::RST_MAC_CTRL;
			st_reg.max_pkt  <= mac_ctl_pkg::RST_MAX_PKT;
			st_reg.tag_mask <= mac_ctl_pkg::RST_TAG_MASK;
		end else begin
			st_reg <= st_next;
		end
	end

	// zero-wait slave: answer in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & st_reg.rerr;
	assign prdata  = st_reg.rdata;

	// receive carrier ignored in full duplex
	assign tx_hold_off = st_reg.defer_cnt != 10'd0 ||
		(st_reg.crs_sync[1] && !full_dup);

	assign upload_status_word   = st_reg.status;
	assign upload_status_valid  = st_reg.status_vld;
	assign pause_seen           = st_reg.pause_vld;
	assign pause_quanta         = st_reg.pause_q;
	assign full_duplex_enable_a = full_dup;
	// duplex change flagged for the host's resets
	assign transmit_reset_cmd   = st_reg.dup_changed;
	assign receive_reset_cmd    = st_reg.dup_changed;
endmodule : mac_control_options

// file: include/mac_ctl_pkg.sv
// package: register map, field layout and timing of the mac control block
// assumes a 100 MHz pclk and a mac that sees one received byte at a time
package mac_ctl_pkg;
	// register byte offsets
	localparam logic [11:0] OFF_MAC_CTRL  = 12'h000;
	localparam logic [11:0] OFF_MAX_PKT   = 12'h004;
	localparam logic [11:0] OFF_TAG_MASK  = 12'h008;
	localparam logic [11:0] OFF_LOST_CARR = 12'h00C;
	// reset values
	localparam logic [15:0] RST_MAC_CTRL  = 16'h0000;
	localparam logic [15:0] RST_MAX_PKT   = 16'h05EE;
	localparam logic [15:0] RST_TAG_MASK  = 16'hFFFF;
	localparam logic [15:0] MAC_CTRL_MASK = 16'h07FF;
	// control field positions
	localparam int B_DEFER_EN   = 0;
	localparam int B_DEFER_SEL  = 1;
	localparam int B_FULL_DUP   = 5;
	localparam int B_LARGE_PKT  = 6;
	localparam int B_COLL_ONLY  = 7;
	localparam int B_PAUSE_EN   = 8;
	localparam int B_VTAG_EN    = 9;
	localparam int B_TAG_OVS    = 10;
	// upload status word fields
	localparam int S_TOO_LONG   = 13;
	localparam int S_TAG_REJ    = 14;
	localparam int S_PAUSE      = 15;
	// frame sizes in bytes
	localparam logic [12:0] OVS_NORMAL = 13'd1519;
	localparam logic [12:0] OVS_LARGE  = 13'd4495;
	localparam logic [12:0] QTAG_EXTRA = 13'd4;
	localparam logic [12:0] VTAG_LEN   = 13'd4;
	localparam logic [12:0] TYPE_POS   = 13'd12;
	localparam logic [15:0] TYPE_QTAG  = 16'h8100;
	localparam logic [15:0] TYPE_CTRL  = 16'h8808;
	localparam logic [15:0] OPC_PAUSE  = 16'h0001;
	// deference in bit times
	localparam logic [9:0] IFS_BITS = 10'd96;
	localparam logic [15:0][8:0] EXT_BITS = '{
		9'd448, 9'd416, 9'd384, 9'd352, 9'd320, 9'd288, 9'd256, 9'd224,
		9'd192, 9'd160, 9'd128, 9'd96, 9'd64, 9'd32, 9'd16, 9'd0};
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_NS_10M    = 100;
	localparam int BIT_NS_100M   = 10;
	localparam logic [3:0] BIT_CYC_10M =
		4'((BIT_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] BIT_CYC_100M =
		4'((BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : mac_ctl_pkg

// file: verif/mac_control_options_chk.sv
// checker: timing relations at the ports of mac_control_options
// assumes it is bound onto the design top, single pclk domain
`timescale 1ns/1ps
module mac_control_options_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// transmit side
	input wire logic        tx_end,
	input wire logic        tx_hold_off,
	// receive side
	input wire logic        rx_end,
	input wire logic [15:0] upload_status_word,
	input wire logic        upload_status_valid,
	input wire logic        pause_seen,
	// configuration
	input wire logic        full_duplex_enable_a,
	input wire logic        transmit_reset_cmd,
	input wire logic        receive_reset_cmd
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_defer;
		tx_end |=> tx_hold_off [*8];
	endproperty
	a_defer: assert property (p_defer)
		else $error("hold off missing after tx end");
	property p_duplex;
		!tx_hold_off && !tx_end ##1 full_duplex_enable_a |-> !tx_hold_off;
	endproperty
	a_duplex: assert property (p_duplex)
		else $error("hold off raised in full duplex");
	property p_cmds;
		$changed(full_duplex_enable_a)
			|-> transmit_reset_cmd && receive_reset_cmd;
	endproperty
	a_cmds: assert property (p_cmds)
		else $error("reset commands not pulsed");
	property p_valid;
		rx_end |=> upload_status_valid;
	endproperty
	a_valid: assert property (p_valid)
		else $error("status not delivered");
	property p_cause;
		upload_status_valid |-> $past(rx_end);
	endproperty
	a_cause: assert property (p_cause)
		else $error("status without frame end");
	property p_large;
		upload_status_valid && upload_status_word[12:0] >= 13'd4495
			|-> upload_status_word[13];
	endproperty
	a_large: assert property (p_large)
		else $error("oversize not flagged");
	property p_pause;
		pause_seen |-> upload_status_valid && upload_status_word[15];
	endproperty
	a_pause: assert property (p_pause)
		else $error("pause outside status");
	property p_reject;
		upload_status_valid && upload_status_word[14] |-> !pause_seen;
	endproperty
	a_reject: assert property (p_reject)
		else $error("rejected frame acted on");
endmodule : mac_control_options_chk

// file: verif/far_end_model.sv
// far end: a hub sending frames byte by byte, carrier up meanwhile
// assumes pclk of the mac; idle data shows the inverse of the last byte
`timescale 1ns/1ps
module far_end_model (
	// clock
	input wire logic       pclk,
	// receive stream
	output logic           carrier_sense_pin,
	output logic           rx_start,
	output logic           rx_byte_valid,
	output logic [7:0]     rx_byte,
	output logic           rx_end
);
	initial begin
		{carrier_sense_pin, rx_start, rx_byte_valid, rx_end} = '0;
		rx_byte = 8'hA5;
	end
	task automatic send(input int n, input logic [15:0] hd,
		input int tp, input logic [15:0] ty, input logic [15:0] qn);
		logic [47:0] w;
		logic [7:0]  b;
		w = {ty, 16'h0001, qn};
		@(posedge pclk);
		carrier_sense_pin <= 1'b1;
		rx_start <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			b = i[7:0];
			if (i < 2)
				b = hd[8*(1-i) +: 8];
			if (i >= tp && i < tp + 6)
				b = w[8*(5-(i-tp)) +: 8];
			rx_start <= 1'b0;
			rx_byte_valid <= 1'b1;
			rx_byte <= b;
		end
		@(posedge pclk);
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_end <= 1'b1;
		carrier_sense_pin <= 1'b0;
		@(posedge pclk);
		rx_end <= 1'b0;
	endtask : send
endmodule : far_end_model

// file: verif/mac_control_options_tb_top.sv
// bench: apb register access, deferral timing, receive checks
// assumes far_end_model drives the receive stream and carrier
`timescale 1ns/1ps
module mac_control_options_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        speed_100_pin, carrier_sense_pin, tx_end, tx_collided;
	logic        tx_was_ours, tx_carrier_lost, tx_hold_off, rx_start;
	logic        rx_byte_valid, rx_end, upload_status_valid, pause_seen;
	logic        full_duplex_enable_a, transmit_reset_cmd, receive_reset_cmd;
	logic [7:0]  rx_byte;
	logic [15:0] upload_status_word, pause_quanta;
	int          n_mismatch, compares;
	int          ext[16] = '{0, 16, 32, 64, 96, 128, 160, 192, 224, 256,
		288, 320, 352, 384, 416, 448};
	mac_control_options mac_control_options_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .speed_100_pin, .carrier_sense_pin, .tx_end, .tx_collided,
		.tx_was_ours, .tx_carrier_lost, .tx_hold_off, .rx_start,
		.rx_byte_valid, .rx_byte, .rx_end, .upload_status_word,
		.upload_status_valid, .pause_seen, .pause_quanta,
		.full_duplex_enable_a, .transmit_reset_cmd, .receive_reset_cmd);
	far_end_model far_end_model_i (.pclk, .carrier_sense_pin, .rx_start,
		.rx_byte_valid, .rx_byte, .rx_end);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 50) begin
			n_mismatch++;
			$display("MISMATCH %0t apb timeout", $time);
			wrap_up();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {16'h0000, d}, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	task automatic defer(input logic c, input logic o, input int lo, hi);
		int n;
		tx_end <= 1'b1;
		tx_collided <= c;
		tx_was_ours <= o;
		@(posedge pclk);
		tx_end <= 1'b0;
		for (n = 0; n < 6000; n++) begin
			@(posedge pclk);
			if (tx_hold_off !== 1'b1)
				break;
		end
		chk(n >= lo && n <= hi, 1);
	endtask : defer
	task automatic fr(input int n, input logic [15:0] hd, input int tp,
		input logic [15:0] ty, input logic [15:0] x);
		far_end_model_i.send(n, hd, tp, ty, 16'h1234);
		// status pulse is sampled at the edge after it is launched
		@(posedge pclk);
		chk({31'h0, upload_status_valid}, 1);
		chk({16'h0, upload_status_word}, {16'h0, x});
		// a tag-rejected pause frame is reported but not acted on
		chk({31'h0, pause_seen}, {31'h0, x[15] & ~x[14]});
		if (x[15] && !x[14])
			chk({16'h0, pause_quanta}, 32'h1234);
	endtask : fr
	initial begin
		{psel, penable, pwrite, tx_end, tx_collided} = '0;
		{tx_was_ours, tx_carrier_lost, presetn} = '0;
		{paddr, pwdata} = '0;
		speed_100_pin = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h000, 0, 0);
		rd(12'h004, 32'h5EE, 0);
		rd(12'h008, 32'hFFFF, 0);
		rd(12'h00C, 0, 0);
		wr(12'h000, 16'hFFFF);
		rd(12'h000, 32'h7FF, 0);
		rd(12'h010, 0, 1);
		for (int c = 0; c < 16; c++) begin
			wr(12'h000, 16'(c * 2 + 1));
			defer(0, 0, 96 + ext[c], 97 + ext[c]);
		end
		wr(12'h000, 16'h001E);
		defer(0, 0, 96, 97);
		wr(12'h000, 16'h0083);
		defer(0, 1, 96, 97);
		defer(1, 0, 96, 97);
		defer(1, 1, 112, 113);
		speed_100_pin <= 1'b0;
		// let the speed pin pass its synchroniser first
		repeat (3) @(posedge pclk);
		// up to one bit of divider phase at the slow rate
		defer(1, 1, 1111, 1120);
		wr(12'h000, 16'h0000);
		defer(0, 0, 951, 960);
		for (int f = 0; f < 2; f++) begin
			// host resets follow inside the device pulse
			wr(12'h000, 16'(f * 32));
			chk({31'h0, full_duplex_enable_a}, 32'(f));
			chk({30'h0, transmit_reset_cmd, receive_reset_cmd},
				32'(3 * f));
			tx_carrier_lost <= 1'b1;
			@(posedge pclk);
			tx_carrier_lost <= 1'b0;
			rd(12'h00C, 1, 0);
			fork
				far_end_model_i.send(120, 16'h0, 12, 16'h0800, 16'h0);
				begin
					repeat (60) @(posedge pclk);
					chk({31'h0, tx_hold_off}, 32'(1 - f));
				end
			join
		end
		wr(12'h000, 16'h0000);
		fr(1518, 16'h0, 12, 16'h0800, 16'h05EE);
		fr(1519, 16'h0, 12, 16'h0800, 16'h25EF);
		wr(12'h000, 16'h0040);
		fr(1519, 16'h0, 12, 16'h8100, 16'h25EF);
		wr(12'h004, 16'h1FFF);
		fr(4494, 16'h0, 12, 16'h0800, 16'h118E);
		fr(4495, 16'h0, 12, 16'h0800, 16'h318F);
		wr(12'h004, 16'h05EE);
		wr(12'h000, 16'h0440);
		fr(1522, 16'h0, 12, 16'h8100, 16'h05F2);
		fr(1523, 16'h0, 12, 16'h8100, 16'h25F3);
		fr(1519, 16'h0, 12, 16'h0800, 16'h25EF);
		wr(12'h000, 16'h0020);
		fr(64, 16'hAB00, 12, 16'h8808, 16'h0040);
		wr(12'h000, 16'h0120);
		fr(64, 16'h0, 12, 16'h8808, 16'h8040);
		wr(12'h008, 16'h00FF);
		wr(12'h000, 16'h0320);
		fr(64, 16'hAB00, 16, 16'h8808, 16'hC040);
		fr(64, 16'h0001, 16, 16'h8808, 16'h8040);
		wrap_up();
	end
	initial begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		$display("MISMATCH %0t run timeout", $time);
		wrap_up();
	end
endmodule : mac_control_options_tb_top
bind mac_control_options mac_control_options_chk mac_control_options_chk_i (
	.pclk, .presetn, .tx_end, .tx_hold_off, .rx_end, .upload_status_word,
	.upload_status_valid, .pause_seen, .full_duplex_enable_a,
	.transmit_reset_cmd, .receive_reset_cmd);
